// file: logic/supply_brownout_supervisor_regs.sv
// Operation
// R1: All resets clear thresholds except reset-threshold bits
// R2: Threshold control bits 15:6 read zero
// R3: Bits 5:4 select I/O-supply interrupt threshold
// R4: I/O flag sets only when detection enabled
// R5: I/O interrupt needs flag, enable, mask, global
// R6: Bits 3:2 select core-supply interrupt threshold
// R7: Core flag sets only when detection enabled
// R8: Core interrupt needs flag, enable, mask, global
// R9: Bits 1:0 select core-supply reset threshold
// R10: Enabled supervisor halts core on low supply
// R11: Reset enable bit set by every reset
// R12: Power enable register resets to 0400h
// R13: Bit 12 enables I/O-supply detection
// R14: Bit 11 enables core-supply detection
// R15: Power enable reserved bits read zero
// R16: Front end controls kept as plain storage
// R17: Processor addresses registers by module and index
// R18: Status read clears both flags, not levels
// R19: Comparators synchronised; set beats read clear
`timescale 1ns/1ps
module supply_brownout_supervisor_regs (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_power_on_reset,
  input wire logic [4:0] i_reg_module,
  input wire logic [4:0] i_reg_index,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [15:0] i_reg_wdata,
  input wire supply_supervisor_pkg::comparator_trip_t i_comparator_trip,
  input wire logic i_module_five_irq_mask,
  input wire logic i_global_irq_enable,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rdata_valid,
  output supply_supervisor_pkg::comparator_ctrl_t o_comparator_ctrl,
  output supply_supervisor_pkg::front_end_ctrl_t o_front_end_ctrl,
  output logic o_supply_irq,
  output logic o_brownout_reset
);

  // Any reset clears most state; power-on reset alone clears the rest
  wire any_reset = i_srst | i_power_on_reset;

  // Register state
  logic [3:0] irq_sel_q;
  logic [1:0] reset_sel_q;
  logic [15:0] power_enable_q;
  logic [15:0] irq_enable_q;
  logic io_flag_q;
  logic core_flag_q;
  logic [15:0] rdata_q;
  logic rdata_valid_q;
  logic irq_q;
  logic brownout_reset_q;
  supply_supervisor_pkg::comparator_ctrl_t ctrl_q;
  supply_supervisor_pkg::front_end_ctrl_t front_end_q;

  // Next values
  logic [3:0] irq_sel_d;
  logic [1:0] reset_sel_d;
  logic [15:0] power_enable_d;
  logic [15:0] irq_enable_d;
  logic io_flag_d;
  logic core_flag_d;
  logic [15:0] rdata_d;
  logic irq_d;
  logic brownout_reset_d;
  supply_supervisor_pkg::comparator_ctrl_t ctrl_d;
  supply_supervisor_pkg::front_end_ctrl_t front_end_d;

  // Comparator answers arrive from the analog side without a clock relation
  supply_supervisor_pkg::comparator_trip_t trip_sync;

  // R19: two-stage synchroniser
  sync_two_stage #(
    .WIDTH($bits(supply_supervisor_pkg::comparator_trip_t))
  ) u_trip_sync (
    .i_clock(i_clock),
    .i_srst(any_reset),
    .i_data(i_comparator_trip),
    .o_data(trip_sync)
  );

  // R17: module and index decode
  wire module_hit = (i_reg_module == supply_supervisor_pkg::MODULE_NUM);
  wire sel_threshold = module_hit
    & (i_reg_index == supply_supervisor_pkg::THRESHOLD_CTRL_INDEX);
  wire sel_power = module_hit & (i_reg_index == supply_supervisor_pkg::POWER_ENABLE_INDEX);
  wire sel_irq_en = module_hit & (i_reg_index == supply_supervisor_pkg::IRQ_ENABLE_INDEX);
  wire sel_status = module_hit & (i_reg_index == supply_supervisor_pkg::STATUS_INDEX);

  wire wr_threshold = i_reg_write & sel_threshold;
  wire wr_power = i_reg_write & sel_power;
  wire wr_irq_en = i_reg_write & sel_irq_en;
  wire rd_status = i_reg_read & sel_status;

  // Enable bits taken from the power enable and interrupt enable registers
  wire io_detect_en = power_enable_q[supply_supervisor_pkg::IO_DETECT_EN_BIT];
  wire core_detect_en = power_enable_q[supply_supervisor_pkg::CORE_DETECT_EN_BIT];
  wire reset_en = power_enable_q[supply_supervisor_pkg::RESET_EN_BIT];
  wire io_irq_en = irq_enable_q[supply_supervisor_pkg::IO_IRQ_EN_BIT];
  wire core_irq_en = irq_enable_q[supply_supervisor_pkg::CORE_IRQ_EN_BIT];

  // R3: I/O interrupt threshold write
  // R6: core interrupt threshold write
  assign irq_sel_d = wr_threshold
    ? i_reg_wdata[supply_supervisor_pkg::IO_IRQ_SEL_LSB+1:supply_supervisor_pkg::CORE_IRQ_SEL_LSB]
    : irq_sel_q;

  // R9: reset threshold write
  assign reset_sel_d = wr_threshold
    ? i_reg_wdata[supply_supervisor_pkg::CORE_RESET_SEL_LSB+1:
                  supply_supervisor_pkg::CORE_RESET_SEL_LSB]
    : reset_sel_q;

  // R13: R14: R11: R15: R16: masked enable storage
  assign power_enable_d = wr_power
    ? (i_reg_wdata & supply_supervisor_pkg::POWER_ENABLE_WRITE_MASK)
    : power_enable_q;

  // Interrupt enables; unimplemented bits never store
  assign irq_enable_d = wr_irq_en
    ? (i_reg_wdata & supply_supervisor_pkg::IRQ_ENABLE_WRITE_MASK)
    : irq_enable_q;

  // R4: I/O flag gated by detection enable
  wire io_set = io_detect_en & trip_sync.io_below_irq;
  // R7: core flag gated by detection enable
  wire core_set = core_detect_en & trip_sync.core_below_irq;

  // R18: R19: read clears flags, a same-cycle set wins
  assign io_flag_d = io_set | (io_flag_q & ~rd_status);
  assign core_flag_d = core_set | (core_flag_q & ~rd_status);

  // Live levels are high above threshold and forced low when disabled
  wire io_level = io_detect_en & ~trip_sync.io_below_irq;
  wire core_level = core_detect_en & ~trip_sync.core_below_irq;

  // R2: threshold control image, upper bits zero
  wire [15:0] threshold_image = {10'h000, irq_sel_q, reset_sel_q};

  // R18: status image holds levels beside the flags
  logic [15:0] status_image;
  always_comb
  begin
    status_image = supply_supervisor_pkg::READ_ZERO;
    status_image[supply_supervisor_pkg::IO_LEVEL_BIT] = io_level;
    status_image[supply_supervisor_pkg::CORE_LEVEL_BIT] = core_level;
    status_image[supply_supervisor_pkg::IO_FLAG_BIT] = io_flag_q;
    status_image[supply_supervisor_pkg::CORE_FLAG_BIT] = core_flag_q;
  end

  // Read mux; unmapped addresses answer zero
  assign rdata_d = sel_threshold ? threshold_image
    : sel_power ? power_enable_q
    : sel_irq_en ? irq_enable_q
    : sel_status ? status_image
    : supply_supervisor_pkg::READ_ZERO;

  // R5: I/O interrupt gating
  wire io_irq = io_flag_q & io_irq_en;
  // R8: core interrupt gating
  wire core_irq = core_flag_q & core_irq_en;
  assign irq_d = (io_irq | core_irq) & i_module_five_irq_mask & i_global_irq_enable;

  // R10: reset supervisor, suppressed when its enable is clear
  assign brownout_reset_d = reset_en & trip_sync.core_below_reset;

  // Selects and enables handed to the comparators, one cycle after the write
  always_comb
  begin
    ctrl_d = '0;
    ctrl_d.io_irq_sel = irq_sel_d[3:2];
    ctrl_d.core_irq_sel = irq_sel_d[1:0];
    ctrl_d.core_reset_sel = reset_sel_d;
    ctrl_d.io_detect_en = power_enable_d[supply_supervisor_pkg::IO_DETECT_EN_BIT];
    ctrl_d.core_detect_en = power_enable_d[supply_supervisor_pkg::CORE_DETECT_EN_BIT];
    ctrl_d.reset_en = power_enable_d[supply_supervisor_pkg::RESET_EN_BIT];
  end

  // R16: front end bits are stored only, with no action here
  always_comb
  begin
    front_end_d = '0;
    front_end_d.gain_code = power_enable_d[supply_supervisor_pkg::GAIN_CODE_LSB+2:
                                           supply_supervisor_pkg::GAIN_CODE_LSB];
    front_end_d.temp_sensor_enable = power_enable_d[supply_supervisor_pkg::TEMP_SENSOR_EN_BIT];
    front_end_d.gain_amp_enable = power_enable_d[supply_supervisor_pkg::GAIN_AMP_EN_BIT];
    front_end_d.output_converter_enable = power_enable_d[supply_supervisor_pkg::OUT_CONV_EN_BIT];
    front_end_d.input_converter_enable = power_enable_d[supply_supervisor_pkg::IN_CONV_EN_BIT];
  end

  // R1: reset-threshold bits survive all but power-on reset
  always_ff @(posedge i_clock)
  begin
    if (i_power_on_reset)
    begin
      reset_sel_q <= supply_supervisor_pkg::SEL_DEFAULT;
    end
    else
    begin
      reset_sel_q <= reset_sel_d;
    end
  end

  // Flags belong to the status register, which only power-on reset clears
  always_ff @(posedge i_clock)
  begin
    if (i_power_on_reset)
    begin
      io_flag_q <= 1'b0;
      core_flag_q <= 1'b0;
    end
    else
    begin
      io_flag_q <= io_flag_d;
      core_flag_q <= core_flag_d;
    end
  end

  // R1: R12: R11: every reset restores the control registers except the reset-threshold bits
  always_ff @(posedge i_clock)
  begin
    if (any_reset)
    begin
      irq_sel_q <= supply_supervisor_pkg::THRESHOLD_CTRL_RESET[5:2];
      power_enable_q <= supply_supervisor_pkg::POWER_ENABLE_RESET;
      irq_enable_q <= supply_supervisor_pkg::IRQ_ENABLE_RESET;
    end
    else
    begin
      irq_sel_q <= irq_sel_d;
      power_enable_q <= power_enable_d;
      irq_enable_q <= irq_enable_d;
    end
  end

  // Output stage; the comparator controls are held at zero during reset
  always_ff @(posedge i_clock)
  begin
    if (any_reset)
    begin
      rdata_q <= supply_supervisor_pkg::READ_ZERO;
      rdata_valid_q <= 1'b0;
      irq_q <= 1'b0;
      brownout_reset_q <= 1'b0;
      ctrl_q <= '0;
      front_end_q <= '0;
    end
    else
    begin
      rdata_q <= i_reg_read ? rdata_d : rdata_q;
      rdata_valid_q <= i_reg_read;
      irq_q <= irq_d;
      brownout_reset_q <= brownout_reset_d;
      ctrl_q <= ctrl_d;
      front_end_q <= front_end_d;
    end
  end

  // Everything leaving the block comes straight from a flop
  assign o_reg_rdata = rdata_q;
  assign o_reg_rdata_valid = rdata_valid_q;
  assign o_comparator_ctrl = ctrl_q;
  assign o_front_end_ctrl = front_end_q;
  assign o_supply_irq = irq_q;
  assign o_brownout_reset = brownout_reset_q;

endmodule

// file: logic/supply_supervisor_pkg.sv
package supply_supervisor_pkg;

  // Peripheral bus addressing: module number and register index
  localparam logic [4:0] MODULE_NUM = 5'h05;
  localparam logic [4:0] THRESHOLD_CTRL_INDEX = 5'h00;
  localparam logic [4:0] POWER_ENABLE_INDEX = 5'h01;
  localparam logic [4:0] IRQ_ENABLE_INDEX = 5'h0a;
  localparam logic [4:0] STATUS_INDEX = 5'h0b;

  // Threshold control register layout
  localparam logic [15:0] THRESHOLD_CTRL_RESET = 16'h0000;
  localparam int IO_IRQ_SEL_LSB = 4;
  localparam int CORE_IRQ_SEL_LSB = 2;
  localparam int CORE_RESET_SEL_LSB = 0;
  localparam logic [1:0] SEL_DEFAULT = 2'h0;

  // Power enable register layout
  localparam logic [15:0] POWER_ENABLE_RESET = 16'h0400;
  localparam logic [15:0] POWER_ENABLE_WRITE_MASK = 16'h1cfb;
  localparam int IO_DETECT_EN_BIT = 12;
  localparam int CORE_DETECT_EN_BIT = 11;
  localparam int RESET_EN_BIT = 10;
  localparam int GAIN_CODE_LSB = 5;
  localparam int TEMP_SENSOR_EN_BIT = 4;
  localparam int GAIN_AMP_EN_BIT = 3;
  localparam int OUT_CONV_EN_BIT = 1;
  localparam int IN_CONV_EN_BIT = 0;

  // Interrupt enable register layout (only the supervisor bits and the user bit)
  localparam logic [15:0] IRQ_ENABLE_RESET = 16'h0001;
  localparam logic [15:0] IRQ_ENABLE_WRITE_MASK = 16'h0031;
  localparam int IO_IRQ_EN_BIT = 5;
  localparam int CORE_IRQ_EN_BIT = 4;

  // Status register layout
  localparam int IO_LEVEL_BIT = 15;
  localparam int CORE_LEVEL_BIT = 14;
  localparam int IO_FLAG_BIT = 5;
  localparam int CORE_FLAG_BIT = 4;

  localparam logic [15:0] READ_ZERO = 16'h0000;

  // Selects and enables presented to the analog comparators
  typedef struct packed {
    logic [1:0] io_irq_sel;
    logic [1:0] core_irq_sel;
    logic [1:0] core_reset_sel;
    logic io_detect_en;
    logic core_detect_en;
    logic reset_en;
  } comparator_ctrl_t;

  // Raw comparator answers; high means the supply lies in the selected range
  typedef struct packed {
    logic io_below_irq;
    logic core_below_irq;
    logic core_below_reset;
  } comparator_trip_t;

  // Analog front end storage bits, routed out untouched
  typedef struct packed {
    logic [2:0] gain_code;
    logic temp_sensor_enable;
    logic gain_amp_enable;
    logic output_converter_enable;
    logic input_converter_enable;
  } front_end_ctrl_t;

endpackage

// file: logic/sync_two_stage.sv
`timescale 1ns/1ps
module sync_two_stage #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [WIDTH-1:0] i_data,
  output logic [WIDTH-1:0] o_data
);

  logic [WIDTH-1:0] first_q;
  logic [WIDTH-1:0] second_q;

  // First stage feeds only the second stage, to let metastability settle
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      first_q <= '0;
      second_q <= '0;
    end
    else
    begin
      first_q <= i_data;
      second_q <= first_q;
    end
  end

  assign o_data = second_q;

endmodule

// file: sim/supply_brownout_supervisor_regs_chk.sv
`timescale 1ns/1ps
module supply_brownout_supervisor_regs_chk (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_power_on_reset,
  input wire logic [4:0] i_reg_module,
  input wire logic [4:0] i_reg_index,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_module_five_irq_mask,
  input wire logic i_global_irq_enable,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_rdata_valid,
  input wire supply_supervisor_pkg::comparator_ctrl_t o_comparator_ctrl,
  input wire supply_supervisor_pkg::front_end_ctrl_t o_front_end_ctrl,
  input wire logic o_supply_irq,
  input wire logic o_brownout_reset
);
  // Strobes decoded for this module only
  wire logic rd_hit = i_reg_read && i_reg_module == 5'h05;
  wire logic wr_thr = i_reg_write && i_reg_module == 5'h05 && i_reg_index == 5'h00;
  wire logic wr_pe = i_reg_write && i_reg_module == 5'h05 && i_reg_index == 5'h01;
  wire logic idx_gap = i_reg_index > 5'h01 && i_reg_index < 5'h0a;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst || i_power_on_reset);
  rd_answer_a: assert property (rd_hit |=> o_reg_rdata_valid)
    else $error("read got no answer");
  unmapped_zero_a: assert property (rd_hit && idx_gap |=> o_reg_rdata == 16'h0000)
    else $error("unmapped index read nonzero");
  thr_resv_a: assert property (rd_hit && i_reg_index == 5'h00 |=>
      o_reg_rdata[15:6] == 10'h000)
    else $error("threshold reserved bits set");
  pe_resv_a: assert property (rd_hit && i_reg_index == 5'h01 |=>
      (o_reg_rdata & 16'he304) == 16'h0000)
    else $error("power enable reserved bits set");
  thr_write_a: assert property (wr_thr |=>
      o_comparator_ctrl[8:3] == $past(i_reg_wdata[5:0]))
    else $error("selects differ from write");
  pe_write_a: assert property (wr_pe |=>
      o_comparator_ctrl[2:0] == $past(i_reg_wdata[12:10]))
    else $error("enables differ from write");
  fe_store_a: assert property (wr_pe |=>
      o_front_end_ctrl == {$past(i_reg_wdata[7:3]), $past(i_reg_wdata[1:0])})
    else $error("front end bits differ from write");
  irq_gate_a: assert property (o_supply_irq |->
      $past(i_module_five_irq_mask && i_global_irq_enable))
    else $error("irq without mask and global enable");
  bor_gate_a: assert property (o_brownout_reset |-> $past(o_comparator_ctrl.reset_en))
    else $error("brownout reset while disabled");
  // Main scenarios reached
  cover property (o_supply_irq);
  cover property (o_brownout_reset);
  cover property (rd_hit && i_reg_index == 5'h0b);
endmodule
bind supply_brownout_supervisor_regs supply_brownout_supervisor_regs_chk chk_i (
  .i_clock(i_clock),
  .i_srst(i_srst),
  .i_power_on_reset(i_power_on_reset),
  .i_reg_module(i_reg_module),
  .i_reg_index(i_reg_index),
  .i_reg_write(i_reg_write),
  .i_reg_read(i_reg_read),
  .i_reg_wdata(i_reg_wdata),
  .i_module_five_irq_mask(i_module_five_irq_mask),
  .i_global_irq_enable(i_global_irq_enable),
  .o_reg_rdata(o_reg_rdata),
  .o_reg_rdata_valid(o_reg_rdata_valid),
  .o_comparator_ctrl(o_comparator_ctrl),
  .o_front_end_ctrl(o_front_end_ctrl),
  .o_supply_irq(o_supply_irq),
  .o_brownout_reset(o_brownout_reset)
);

// file: sim/supply_brownout_supervisor_regs_tb.sv
`timescale 1ns/1ps
module supply_brownout_supervisor_regs_tb;
  logic i_clock = 1'b0;
  logic srst = 1'b1;
  logic por = 1'b1;
  logic [4:0] mod = 5'h05;
  logic [4:0] idx = 5'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic mask = 1'b0;
  logic glob = 1'b0;
  logic [2:0] io_step = 3'h7;
  logic [2:0] core_step = 3'h7;
  logic [15:0] lfsr_q = 16'h002c;
  supply_supervisor_pkg::comparator_trip_t trip;
  supply_supervisor_pkg::comparator_ctrl_t ctrl;
  supply_supervisor_pkg::front_end_ctrl_t fe;
  logic [15:0] rdata;
  logic valid;
  logic irq;
  logic bor;
  int error_cnt = 0;
  int tests_run = 0;
  // Design and its comparators
  supply_brownout_supervisor_regs DUT (.i_clock(i_clock), .i_srst(srst),
    .i_power_on_reset(por), .i_reg_module(mod), .i_reg_index(idx), .i_reg_write(wr),
    .i_reg_read(rd), .i_reg_wdata(wd), .i_comparator_trip(trip),
    .i_module_five_irq_mask(mask), .i_global_irq_enable(glob), .o_reg_rdata(rdata),
    .o_reg_rdata_valid(valid), .o_comparator_ctrl(ctrl), .o_front_end_ctrl(fe),
    .o_supply_irq(irq), .o_brownout_reset(bor));
  supply_comparator_model cmp (.i_ctrl(ctrl), .i_io_step(io_step),
    .i_core_step(core_step), .o_trip(trip));
  // Clock, 50 ns period
  initial
  begin
    forever #25 i_clock = ~i_clock;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Expected read images: only the writable fields survive a write
  function automatic logic [15:0] thr_exp(input logic [15:0] v);
    return v & 16'h003f;
  endfunction
  function automatic logic [15:0] pe_exp(input logic [15:0] v);
    return v & 16'h1cfb;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One strobe cycle; the leading wait keeps back-to-back calls from reassigning a strobe
  task automatic bus(input logic w, input logic [4:0] m, input logic [4:0] i,
    input logic [15:0] v);
    @(negedge i_clock);
    mod = m;
    idx = i;
    wd = v;
    wr = w;
    rd = !w;
    @(negedge i_clock);
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] i, input logic [15:0] exp);
    bus(1'b0, 5'h05, i, 16'h0000);
    check({15'h0000, valid}, 16'h0001);
    check(rdata, exp);
  endtask
  task automatic pulse(input logic p);
    @(negedge i_clock);
    por = p;
    srst = !p;
    repeat (2) @(negedge i_clock);
    por = 1'b0;
    srst = 1'b0;
  endtask
  task automatic conclude;
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, far beyond the roughly 150 cycles the sequence needs
  initial
  begin
    repeat (4000) @(posedge i_clock);
    error_cnt++;
    conclude();
  end
  // Main sequence
  initial
  begin
    repeat (12) @(negedge i_clock);
    srst = 1'b0;
    por = 1'b0;
    rd_chk(5'h00, 16'h0000);
    rd_chk(5'h01, 16'h0400);
    rd_chk(5'h03, 16'h0000);
    rd_chk(5'h0a, 16'h0001);
    repeat (8)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      bus(1'b1, 5'h05, 5'h00, lfsr_q);
      check({10'h000, ctrl[8:3]}, thr_exp(lfsr_q));
      rd_chk(5'h00, thr_exp(lfsr_q));
      bus(1'b1, 5'h05, 5'h01, lfsr_q);
      bus(1'b1, 5'h06, 5'h01, ~lfsr_q);
      rd_chk(5'h01, pe_exp(lfsr_q));
      check({9'h000, fe}, {9'h000, lfsr_q[7:3], lfsr_q[1:0]});
    end
    bus(1'b1, 5'h05, 5'h00, 16'hffff);
    pulse(1'b0);
    rd_chk(5'h00, 16'h0003);
    rd_chk(5'h01, 16'h0400);
    pulse(1'b1);
    rd_chk(5'h00, 16'h0000);
    io_step = 3'h0;
    core_step = 3'h0;
    repeat (5) @(negedge i_clock);
    check({15'h0000, bor}, 16'h0001);
    rd_chk(5'h0b, 16'h0000);
    bus(1'b1, 5'h05, 5'h01, 16'h1800);
    bus(1'b1, 5'h05, 5'h0a, 16'h0030);
    mask = 1'b1;
    glob = 1'b1;
    repeat (5) @(negedge i_clock);
    check({14'h0000, irq, bor}, 16'h0002);
    glob = 1'b0;
    repeat (2) @(negedge i_clock);
    check({15'h0000, irq}, 16'h0000);
    io_step = 3'h7;
    core_step = 3'h7;
    repeat (5) @(negedge i_clock);
    rd_chk(5'h0b, 16'hc030);
    rd_chk(5'h0b, 16'hc000);
    bus(1'b1, 5'h05, 5'h00, 16'h0030);
    io_step = 3'h3;
    repeat (5) @(negedge i_clock);
    rd_chk(5'h0b, 16'h4020);
    // Trip still present at the read, so the flag set beats the read clear
    rd_chk(5'h0b, 16'h4020);
    conclude();
  end
endmodule

// file: sim/supply_comparator_model.sv
`timescale 1ns/1ps
module supply_comparator_model (
  input wire supply_supervisor_pkg::comparator_ctrl_t i_ctrl,
  input wire logic [2:0] i_io_step,
  input wire logic [2:0] i_core_step,
  output supply_supervisor_pkg::comparator_trip_t o_trip
);
  // Trip when the supply step is at or below the selected level; analog, so no clock
  // select sets level
  // One driver for the whole struct, fields in declaration order
  assign o_trip = {
    i_io_step <= {1'b0, i_ctrl.io_irq_sel},
    i_core_step <= {1'b0, i_ctrl.core_irq_sel},
    i_core_step <= {1'b0, i_ctrl.core_reset_sel}
  };
endmodule
